// file: rtl/rsu_rotate_shift_unit.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Notes on behaviour
// RL1: rotate left into working register, flags kept
// RL2: left through carry, write back memory
// RL3: left through carry into working, memory kept
// RL4: rotate right in place, no flags
// RL5: rotate right into working, flags kept
// RL6: right through carry, write memory, carry
// ==========================================================
// rotate datapath: one request, result one cycle later
module rsu_rotate_shift_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [7:0] mem_data,
  input wire logic carry_in,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic [7:0] working_register,
  output logic working_we,
  output logic carry_out,
  output logic carry_we,
  output logic done
);
  // decode wires, state and next values of the result registers
  rsu_pkg::rsu_op_type op;
  rsu_pkg::rsu_state_type state;
  rsu_pkg::rsu_state_type next_state;
  logic [7:0] rot_result;
  logic rot_out;
  logic next_left;
  logic next_uses_carry;
  logic next_fill;
  logic next_to_mem;
  logic next_to_work;
  logic known_op;
  logic take;
  logic [7:0] next_mem_wdata;
  logic [7:0] next_working;
  logic next_carry;

  // ==========================================================
  // opcode decode
  assign op = rsu_pkg::rsu_op_type'(op_code);
  assign next_left = (op == rsu_pkg::RSU_OP_ROTATE_LEFT_TO_WORKING) ||
                     (op == rsu_pkg::RSU_OP_ROTATE_LEFT_VIA_CARRY) ||
                     (op == rsu_pkg::RSU_OP_ROTATE_LEFT_VIA_CARRY_TO_WORKING);
  assign next_uses_carry = (op == rsu_pkg::RSU_OP_ROTATE_LEFT_VIA_CARRY) ||
                           (op == rsu_pkg::RSU_OP_ROTATE_LEFT_VIA_CARRY_TO_WORKING) ||
                           (op == rsu_pkg::RSU_OP_ROTATE_RIGHT_VIA_CARRY); // RL2 RL3 RL6
  assign next_to_mem = (op == rsu_pkg::RSU_OP_ROTATE_LEFT_VIA_CARRY) ||
                       (op == rsu_pkg::RSU_OP_ROTATE_RIGHT_IN_PLACE) ||
                       (op == rsu_pkg::RSU_OP_ROTATE_RIGHT_VIA_CARRY); // RL2 RL4 RL6
  assign next_to_work = (op == rsu_pkg::RSU_OP_ROTATE_LEFT_TO_WORKING) ||
                        (op == rsu_pkg::RSU_OP_ROTATE_LEFT_VIA_CARRY_TO_WORKING) ||
                        (op == rsu_pkg::RSU_OP_ROTATE_RIGHT_TO_WORKING); // RL1 RL3 RL5
  assign known_op = next_to_mem || next_to_work;
  // plain rotates feed back the bit that falls out, carry forms feed old carry
  assign next_fill = next_uses_carry ? carry_in :
                     (next_left ? mem_data[rsu_pkg::MSB] : mem_data[rsu_pkg::LSB]);

  rsu_rotator u_rot (
    .operand(mem_data),
    .dir_left(next_left),
    .fill(next_fill),
    .result(rot_result),
    .out_bit(rot_out)
  );

  // ==========================================================
  // state: one result cycle per accepted request
  always_comb begin
    case (state)
      rsu_pkg::RSU_IDLE: next_state = (op_valid && known_op) ? rsu_pkg::RSU_DONE :
                                      rsu_pkg::RSU_IDLE;
      rsu_pkg::RSU_DONE: next_state = rsu_pkg::RSU_IDLE;
      default: next_state = rsu_pkg::RSU_IDLE;
    endcase
  end

  assign done = (state == rsu_pkg::RSU_DONE);

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rsu_pkg::RSU_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // accept strobe: idle, valid and a code the unit knows
  assign take = (state == rsu_pkg::RSU_IDLE) && op_valid && known_op;

  // result values: load only when the request targets them, else hold
  assign next_mem_wdata = (take && next_to_mem) ? rot_result : mem_wdata; // RL2 RL4 RL6
  assign next_working = (take && next_to_work) ? rot_result : working_register; // RL1 RL3 RL5
  assign next_carry = (take && next_uses_carry) ? rot_out : carry_out; // RL2 RL3 RL6

  // write strobes: one-cycle pulses in the result cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we <= 1'h0;
      working_we <= 1'h0;
      carry_we <= 1'h0;
    end else begin
      mem_we <= take && next_to_mem; // RL2 RL4 RL6
      working_we <= take && next_to_work; // RL1 RL3 RL5
      carry_we <= take && next_uses_carry; // RL2 RL3 RL6
    end
  end

  // memory write data, loaded by the memory forms only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wdata <= rsu_pkg::RESET_BYTE;
    end else begin
      mem_wdata <= next_mem_wdata;
    end
  end

  // working register, loaded by the working forms only; memory is left alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      working_register <= rsu_pkg::RESET_BYTE;
    end else begin
      working_register <= next_working;
    end
  end

  // new carry, loaded by the carry forms only; plain rotates keep it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_out <= rsu_pkg::RESET_CARRY;
    end else begin
      carry_out <= next_carry;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a request taken with the given code
  sequence s_take(logic [2:0] c);
    state == rsu_pkg::RSU_IDLE && op_valid && op_code == c;
  endsequence

  // a request with any of the six known codes
  sequence s_take_known;
    state == rsu_pkg::RSU_IDLE && op_valid && op_code != 3'h0 && op_code != 3'h7;
  endsequence

  // a request with a code the unit ignores
  sequence s_unknown_code;
    state == rsu_pkg::RSU_IDLE && op_valid && (op_code == 3'h0 || op_code == 3'h7);
  endsequence

  // a request that falls into the result cycle
  sequence s_busy_request;
    done && op_valid;
  endsequence

  // a cycle with no result and no strobe
  sequence s_quiet;
    !done && !mem_we && !working_we && !carry_we;
  endsequence

  // left forms: bit 7 leaves, the fill bit enters bit 0
  a_left_working: assert property ( // RL1
    s_take(3'h1) |=> working_we && !mem_we && !carry_we &&
    working_register == {$past(mem_data[6:0]), $past(mem_data[7])})
    else $error("left to working wrong");
  a_left_carry_mem: assert property ( // RL2
    s_take(3'h2) |=> mem_we && carry_we && !working_we &&
    mem_wdata == {$past(mem_data[6:0]), $past(carry_in)} && carry_out == $past(mem_data[7]))
    else $error("left via carry wrong");
  a_left_carry_work: assert property ( // RL3
    s_take(3'h3) |=> working_we && carry_we && !mem_we &&
    working_register == {$past(mem_data[6:0]), $past(carry_in)} &&
    carry_out == $past(mem_data[7]))
    else $error("left via carry to working wrong");

  // right forms: bit 0 leaves, the fill bit enters bit 7
  a_right_in_place: assert property ( // RL4
    s_take(3'h4) |=> mem_we && !carry_we && !working_we &&
    mem_wdata == {$past(mem_data[0]), $past(mem_data[7:1])})
    else $error("right in place wrong");
  a_right_working: assert property ( // RL5
    s_take(3'h5) |=> working_we && !carry_we && !mem_we &&
    working_register == {$past(mem_data[0]), $past(mem_data[7:1])})
    else $error("right to working wrong");
  a_right_carry: assert property ( // RL6
    s_take(3'h6) |=> mem_we && carry_we && !working_we &&
    mem_wdata == {$past(carry_in), $past(mem_data[7:1])} && carry_out == $past(mem_data[0]))
    else $error("right via carry wrong");

  // carry moves only with its strobe; the result cycle is a single pulse
  a_carry_hold: assert property (!carry_we |=> $stable(carry_out) || carry_we) // RL1
    else $error("carry changed without strobe");
  a_done_single: assert property (done |=> !done && !mem_we && !working_we) // RL4
    else $error("done not single cycle");

  // accepted request: one result cycle, then quiet again
  a_take_then_done: assert property (s_take_known |=> done ##1 s_quiet)
    else $error("result cycle timing wrong");

  // ignored codes and requests in the result cycle leave no trace
  a_ignore_code: assert property (s_unknown_code |=> s_quiet)
    else $error("unknown code acted on");
  a_busy_refused: assert property (s_busy_request |=> s_quiet)
    else $error("request in result cycle acted on");

  // strobes only come in the result cycle
  a_strobe_done: assert property ((mem_we || working_we || carry_we) |-> done)
    else $error("strobe outside result cycle");

  // working forms never write memory
  a_one_target: assert property (!(mem_we && working_we)) // RL3
    else $error("memory and working written together");

  // data outputs move only with their strobe
  a_mem_hold: assert property ($changed(mem_wdata) |-> mem_we) // RL4
    else $error("memory data changed without strobe");
  a_work_hold: assert property ($changed(working_register) |-> working_we) // RL2
    else $error("working register changed without strobe");
endmodule
`default_nettype wire

// file: rtl/rsu_pkg.sv
// ==========================================================
// rotate unit shared constants
package rsu_pkg;
  localparam int DATA_W = 8;
  localparam int MSB = 7;
  localparam int LSB = 0;
  localparam int OP_W = 3;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam logic RESET_CARRY = 1'h0;
  typedef enum logic [2:0] {
    RSU_OP_NONE = 3'h0,
    RSU_OP_ROTATE_LEFT_TO_WORKING = 3'h1,
    RSU_OP_ROTATE_LEFT_VIA_CARRY = 3'h2,
    RSU_OP_ROTATE_LEFT_VIA_CARRY_TO_WORKING = 3'h3,
    RSU_OP_ROTATE_RIGHT_IN_PLACE = 3'h4,
    RSU_OP_ROTATE_RIGHT_TO_WORKING = 3'h5,
    RSU_OP_ROTATE_RIGHT_VIA_CARRY = 3'h6
  } rsu_op_type;
  typedef enum logic [0:0] {
    RSU_IDLE = 1'h0,
    RSU_DONE = 1'h1
  } rsu_state_type;
endpackage

// file: rtl/rsu_rotator.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// one-bit rotator, fill bit chosen by caller
module rsu_rotator (
  input wire logic [7:0] operand,
  input wire logic dir_left,
  input wire logic fill,
  output logic [7:0] result,
  output logic out_bit
);
  // left shifts fill into bit 0, right shifts fill into bit 7
  assign result = dir_left ? {operand[6:0], fill} : {fill, operand[7:1]};
  assign out_bit = dir_left ? operand[7] : operand[0];
endmodule
`default_nettype wire

// file: dv/test_rotate_shift_unit.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench for the rotate datapath
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; $display("wrong value at %0t: check %0d", $time, compares); end end
module test_rotate_shift_unit;
  localparam int MAX_CYCLES = 400; // reset, 66 requests of at most 3 cycles, reset test, margin
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic op_valid = 1'h0;
  logic [2:0] op_code = 3'h0;
  logic [7:0] mem_data = 8'h00;
  logic carry_in = 1'h0;
  logic [7:0] mem_wdata, working_register;
  logic mem_we, working_we, carry_out, carry_we, done;
  logic [31:0] seed = 32'h00000025;
  logic [7:0] exp_work = 8'h00;
  logic [7:0] exp_mem = 8'h00;
  logic exp_carry = 1'h0;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  // clock generation, 20 ns period
  always #10 clk = ~clk;
  rsu_rotate_shift_unit dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .mem_data(mem_data), .carry_in(carry_in), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .working_register(working_register), .working_we(working_we), .carry_out(carry_out),
    .carry_we(carry_we), .done(done));
  // repeatable random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // expected {carry, result} for one operation
  function automatic logic [8:0] expect_rot(input logic [2:0] op, input logic [7:0] d,
      input logic c);
    case (op)
      3'h1: return {c, d[6:0], d[7]};
      3'h2, 3'h3: return {d[7], d[6:0], c};
      3'h4, 3'h5: return {c, d[0], d[7:1]};
      3'h6: return {d[0], c, d[7:1]};
      default: return {c, d};
    endcase
  endfunction
  // closing report
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one request, then check strobes and every output in the result cycle; with busy set
  // a second request sits in the result cycle and must leave no trace
  task automatic run_op(input logic [2:0] op, input logic [7:0] d, input logic c,
      input logic busy);
    logic [8:0] e;
    logic wf, mf, cf;
    e = expect_rot(op, d, c);
    wf = (op == 3'h1) || (op == 3'h3) || (op == 3'h5);
    mf = (op == 3'h2) || (op == 3'h4) || (op == 3'h6);
    cf = (op == 3'h2) || (op == 3'h3) || (op == 3'h6);
    @(posedge clk);
    op_valid <= 1'h1;
    op_code <= op;
    mem_data <= d;
    carry_in <= c;
    @(posedge clk);
    op_valid <= busy;
    mem_data <= ~d;
    carry_in <= ~c;
    @(negedge clk);
    if (wf) exp_work = e[7:0];
    if (mf) exp_mem = e[7:0];
    if (cf) exp_carry = e[8];
    `CHK(done, wf | mf)
    `CHK(mem_we, mf)
    `CHK(working_we, wf)
    `CHK(carry_we, cf)
    `CHK(working_register, exp_work)
    `CHK(mem_wdata, exp_mem)
    `CHK(carry_out, exp_carry)
    if (busy) begin
      @(posedge clk);
      op_valid <= 1'h0;
      @(negedge clk);
      `CHK(done, 1'h0)
      `CHK(mem_we, 1'h0)
      `CHK(working_we, 1'h0)
      `CHK(carry_we, 1'h0)
      `CHK(working_register, exp_work)
      `CHK(mem_wdata, exp_mem)
      `CHK(carry_out, exp_carry)
    end
    $display("test op %0d data %0h carry %0d busy %0d ended", op, d, c, busy);
  endtask
  // reset in mid-run: every output back to its reset value, expectations follow
  task automatic run_reset();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    exp_work = rsu_pkg::RESET_BYTE;
    exp_mem = rsu_pkg::RESET_BYTE;
    exp_carry = rsu_pkg::RESET_CARRY;
    `CHK(done, 1'h0)
    `CHK(mem_we, 1'h0)
    `CHK(working_we, 1'h0)
    `CHK(carry_we, 1'h0)
    `CHK(working_register, exp_work)
    `CHK(mem_wdata, exp_mem)
    `CHK(carry_out, exp_carry)
    @(posedge clk);
    rst_n <= 1'h1;
    $display("test reset ended");
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      miscompares++;
      end_of_test();
    end
  end
  // main sequence: reset, corner cases, a mid-run reset, then random operations
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      run_op(i[2:0], 8'h81, 1'h0, 1'h0);
      run_op(i[2:0], 8'h7E, 1'h1, 1'h1);
    end
    run_reset();
    repeat (50) begin
      seed = xorshift(seed);
      run_op(seed[2:0], seed[15:8], seed[16], seed[20]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
